// *** core/naf_map.vh ***
// Purpose: Register map, field positions, reset values and timing constants
//          of the notch averaging filter.
// Assumes: 32-bit AXI4-Lite register words, 125 MHz clock.
// Notes:   Definitions only; included by bare name.
`ifndef NAF_MAP_VH
`define NAF_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define NAF_OFF_CTRL      8'h00
`define NAF_OFF_NOTCH     8'h04
`define NAF_OFF_SETTLE    8'h08
`define NAF_OFF_STATUS    8'h0C
`define NAF_OFF_RESULT    8'h10
`define NAF_OFF_NSAMP     8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define NAF_CTRL_START    0
`define NAF_CTRL_BRIDGE   1
`define NAF_ST_BUSY       0
`define NAF_ST_NEMPTY     1
`define NAF_ST_FULL       2
`define NAF_ST_CFGERR     3

// ****************************************************************
// Reset values
// ****************************************************************
`define NAF_RST_NOTCH     16'h0032
`define NAF_RST_SETTLE    16'h0000

// ****************************************************************
// Rates and times
// ****************************************************************
// Converter output rate, 93750 samples per second
`define NAF_ADC_RATE      17'h16E36
`define NAF_CLK_PERIOD_NS 8
`define NAF_US_NS         1000
// Built-in settling delay in microseconds (450)
`define NAF_DEF_SETTLE_US 16'h01C2
// Fixed per-result overhead in microseconds
`define NAF_OVH_US        2

`endif

// *** core/naf_fifo.v ***
// Purpose: Result FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Storage is flip-flops indexed by read and write pointers.
`timescale 1ns/1ps
`default_nettype none

module naf_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // Fill level
  output reg  [AW:0]      count
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage words
  reg [AW-1:0]    wr_ptr;           // Next write slot
  reg [AW-1:0]    rd_ptr;           // Oldest word
  wire            push;             // Word enters
  wire            pop;              // Word leaves

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage write
  always @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and level
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // naf_fifo

`default_nettype wire

// *** core/naf_div.v ***
// Purpose: Sequential unsigned restoring divider.
// Assumes: Divisor nonzero; start ignored while busy.
// Notes:   Takes WIDTH cycles after start; done pulses one cycle.
`timescale 1ns/1ps
`default_nettype none

module naf_div #(
  parameter WIDTH = 48,
  parameter CW    = 6
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Request
  input  wire             start,
  input  wire [WIDTH-1:0] dividend,
  input  wire [WIDTH-1:0] divisor,
  // Answer
  output reg              busy,
  output reg              done,
  output reg  [WIDTH-1:0] quotient
);

  reg  [WIDTH:0]   rem;    // Partial remainder
  reg  [WIDTH-1:0] dvs;    // Latched divisor
  reg  [CW-1:0]    cnt;    // Bits still to do
  wire [WIDTH:0]   shl;    // Remainder shifted with next bit
  wire             fits;   // Divisor fits this step

  assign shl  = {rem[WIDTH-1:0], quotient[WIDTH-1]};
  assign fits = (shl >= {1'b0, dvs});

  // One quotient bit per cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      quotient <= {WIDTH{1'b0}};
      rem      <= {(WIDTH+1){1'b0}};
      dvs      <= {WIDTH{1'b0}};
      cnt      <= {CW{1'b0}};
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        quotient <= dividend;
        dvs      <= divisor;
        rem      <= {(WIDTH+1){1'b0}};
        cnt      <= WIDTH[CW-1:0];
        busy     <= 1'b1;
      end else if (busy) begin
        rem      <= fits ? (shl - {1'b0, dvs}) : shl;
        quotient <= {quotient[WIDTH-2:0], fits};
        cnt      <= cnt - 1'b1;
        if (cnt == {{(CW-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule // naf_div

`default_nettype wire

// *** core/naf_top.v ***
// Purpose: Measurement sequencer and averaging notch filter behind a
//          sigma-delta converter, with AXI4-Lite registers.
// Assumes: Converter samples arrive on aclk with a one-cycle valid.
// Notes:   Results queue in an 8-word FIFO; reading RESULT pops one.
`timescale 1ns/1ps
`default_nettype none
`include "naf_map.vh"

// Contract
// - Result is mean of consecutive samples
// - Count is rate over notch, half up
// - Averaging lasts one notch period
// - Notches at notch frequency and multiples
// - Accept 50 Hz and 60 Hz settings
// - Zero setting selects built-in settling delay
// - Settle, then average, then fixed overhead
// - Bridge mode settles in four sub-measurements
module naf_top #(
  parameter [15:0] DEF_SETTLE_US = `NAF_DEF_SETTLE_US
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Converter sample stream
  input  wire [23:0] adc_sample,
  input  wire        adc_sample_valid,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ****************************************************************
  // Timing constants
  // ****************************************************************
  localparam integer CYC_PER_US = `NAF_US_NS / `NAF_CLK_PERIOD_NS;
  localparam integer OVH_CYC    = `NAF_OVH_US * CYC_PER_US;
  localparam integer US_LAST    = CYC_PER_US - 1;
  localparam integer OVH_LAST   = OVH_CYC - 1;

  // Sequencer states
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_CALC   = 3'h1;
  localparam [2:0] S_SETTLE = 3'h2;
  localparam [2:0] S_AVG    = 3'h3;
  localparam [2:0] S_MEAN   = 3'h4;
  localparam [2:0] S_OVH    = 3'h5;
  localparam [2:0] S_PUSH   = 3'h6;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [15:0] first_notch_freq;      // Notch setting in Hz
  reg  [15:0] settle_delay_setting;  // Settling setting in us
  reg         bridge_mode;           // Four sub-measurements
  reg         cfg_err;               // Sticky bad-notch flag
  reg  [7:0]  aw_addr;               // Held write address
  reg         aw_held;               // Write address taken
  reg  [31:0] w_data;                // Held write data
  reg  [3:0]  w_strb;                // Held write strobes
  reg         w_held;                // Write data taken
  reg  [2:0]  state;                 // Sequencer state
  reg  [16:0] n_samp;                // Samples per result
  reg  [16:0] scnt;                  // Samples taken so far
  reg  [47:0] acc;                   // Sample accumulator
  reg  [6:0]  us_pre;                // Cycles within a us
  reg  [15:0] us_cnt;                // Settling us left
  reg  [8:0]  ovh_cnt;               // Overhead cycles left
  reg  [1:0]  sub;                   // Sub-measurement index
  reg         neg;                   // Sum was negative
  reg  [31:0] result;                // Mean awaiting queue
  reg         div_go;                // Divider start pulse
  reg  [47:0] div_a;                 // Dividend
  reg  [47:0] div_b;                 // Divisor
  wire        div_done;              // Quotient ready
  wire [47:0] div_q;                 // Quotient
  wire        fifo_in_ready;         // Queue has room
  wire        fifo_out_valid;        // Queue holds a result
  wire [31:0] fifo_out_data;         // Oldest result
  wire [3:0]  fifo_count;            // Queue level
  wire        fifo_pop;              // Read of RESULT
  wire        wr_fire;               // Register write now
  wire        rd_fire;               // Register read now
  wire [31:0] wmask;                 // Strobe byte mask
  wire [31:0] ctrl_new;              // Masked control write
  wire        start_req;             // Start bit written
  wire [15:0] settle_us;             // Effective settling
  wire [47:0] acc_next;              // Sum with this sample
  wire [1:0]  sub_last;              // Final sub index

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wmask         = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign ctrl_new      = w_data & wmask;
  assign start_req     = wr_fire && (aw_addr == `NAF_OFF_CTRL) && ctrl_new[`NAF_CTRL_START];

  // Address and data taken in either order, answered once both held
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `NAF_OFF_CTRL, `NAF_OFF_NOTCH, `NAF_OFF_SETTLE, `NAF_OFF_STATUS: begin
            s_axi_bresp <= 2'h0;
          end
          default: begin
            s_axi_bresp <= 2'h2;  // Unmapped or read-only: SLVERR
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable settings and sticky error flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      first_notch_freq     <= `NAF_RST_NOTCH;
      settle_delay_setting <= `NAF_RST_SETTLE;
      bridge_mode          <= 1'b0;
      cfg_err              <= 1'b0;
    end else begin
      if (wr_fire && aw_addr == `NAF_OFF_CTRL && w_strb[0]) begin
        bridge_mode <= w_data[`NAF_CTRL_BRIDGE];
      end
      if (wr_fire && aw_addr == `NAF_OFF_NOTCH) begin
        first_notch_freq <= (first_notch_freq & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
      end
      if (wr_fire && aw_addr == `NAF_OFF_SETTLE) begin
        settle_delay_setting <= (settle_delay_setting & ~wmask[15:0])
                                | (w_data[15:0] & wmask[15:0]);
      end
      // A zero notch cannot place a notch; setting wins over a clear
      if (start_req && state == S_IDLE && first_notch_freq == 16'h0000) begin
        cfg_err <= 1'b1;
      end else if (wr_fire && aw_addr == `NAF_OFF_STATUS && ctrl_new[`NAF_ST_CFGERR]) begin
        cfg_err <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign fifo_pop      = rd_fire && (s_axi_araddr == `NAF_OFF_RESULT);

  // Read data registered one cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `NAF_OFF_CTRL: begin
          s_axi_rdata <= {30'h00000000, bridge_mode, 1'b0};
        end
        `NAF_OFF_NOTCH: begin
          s_axi_rdata <= {16'h0000, first_notch_freq};
        end
        `NAF_OFF_SETTLE: begin
          s_axi_rdata <= {16'h0000, settle_delay_setting};
        end
        `NAF_OFF_STATUS: begin
          s_axi_rdata <= {12'h000, 2'h0, sub, 5'h00, state, fifo_count,
                          cfg_err, !fifo_in_ready, fifo_out_valid, (state != S_IDLE)};
        end
        `NAF_OFF_RESULT: begin
          // Empty queue reads zero; the pop only happens when valid
          s_axi_rdata <= fifo_out_valid ? fifo_out_data : 32'h00000000;
        end
        `NAF_OFF_NSAMP: begin
          s_axi_rdata <= {15'h0000, n_samp};
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  // default settling on zero
  assign settle_us = (settle_delay_setting == 16'h0000) ? DEF_SETTLE_US : settle_delay_setting;
  assign acc_next  = acc + {{24{adc_sample[23]}}, adc_sample};
  assign sub_last  = bridge_mode ? 2'h3 : 2'h0;

  // Settle, average, divide, overhead, queue
  always @(posedge aclk) begin
    if (!aresetn) begin
      state   <= S_IDLE;
      n_samp  <= 17'h00000;
      scnt    <= 17'h00000;
      acc     <= 48'h000000000000;
      us_pre  <= 7'h00;
      us_cnt  <= 16'h0000;
      ovh_cnt <= 9'h000;
      sub     <= 2'h0;
      neg     <= 1'b0;
      result  <= 32'h00000000;
      div_go  <= 1'b0;
      div_a   <= 48'h000000000000;
      div_b   <= 48'h000000000000;
    end else begin
      div_go <= 1'b0;
      case (state)
        S_IDLE: begin
          // (2*rate + f) / (2*f) rounds halves up
          if (start_req && first_notch_freq != 16'h0000) begin
            div_a <= {30'h00000000, `NAF_ADC_RATE, 1'b0} + {32'h00000000, first_notch_freq};
            div_b <= {31'h00000000, first_notch_freq, 1'b0};
            div_go <= 1'b1;
            sub    <= 2'h0;
            state  <= S_CALC;
          end
        end
        S_CALC: begin
          // any nonzero notch, 50 and 60 Hz included
          if (div_done) begin
            n_samp <= div_q[16:0];
            us_cnt <= settle_us;
            us_pre <= 7'h00;
            state  <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (us_pre == US_LAST[6:0]) begin
            us_pre <= 7'h00;
            if (us_cnt <= 16'h0001) begin
              acc   <= 48'h000000000000;
              scnt  <= 17'h00000;
              state <= S_AVG;
            end else begin
              us_cnt <= us_cnt - 16'h0001;
            end
          end else begin
            us_pre <= us_pre + 7'h01;
          end
        end
        S_AVG: begin
          // n samples span one notch period
          if (adc_sample_valid) begin
            acc  <= acc_next;
            scnt <= scnt + 17'h00001;
            if (scnt == n_samp - 17'h00001) begin
              neg    <= acc_next[47];
              div_a  <= acc_next[47] ? (48'h000000000000 - acc_next) : acc_next;
              div_b  <= {31'h00000000, n_samp};
              div_go <= 1'b1;
              state  <= S_MEAN;
            end
          end
        end
        S_MEAN: begin
          // boxcar puts nulls at f and multiples
          if (div_done) begin
            result  <= neg ? (32'h00000000 - div_q[31:0]) : div_q[31:0];
            ovh_cnt <= OVH_LAST[8:0];
            state   <= S_OVH;
          end
        end
        S_OVH: begin
          if (ovh_cnt == 9'h000) begin
            state <= S_PUSH;
          end else begin
            ovh_cnt <= ovh_cnt - 9'h001;
          end
        end
        S_PUSH: begin
          // Full queue stalls the sequencer here
          if (fifo_in_ready) begin
            if (sub == sub_last) begin
              state <= S_IDLE;
            end else begin
              sub    <= sub + 2'h1;
              us_cnt <= settle_us;
              us_pre <= 7'h00;
              state  <= S_SETTLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Shared divider and result queue
  // ****************************************************************
  naf_div #(
    .WIDTH (48),
    .CW    (6)
  ) u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (div_go),
    .dividend (div_a),
    .divisor  (div_b),
    .busy     (),
    .done     (div_done),
    .quotient (div_q)
  );

  naf_fifo #(
    .WIDTH (32),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (state == S_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (result),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

endmodule // naf_top

`default_nettype wire

// *** bench/naf_chk.sv ***
// Purpose: Handshake checks on the register bus of the filter top.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every naf_top instance.
`timescale 1ns/1ps
`default_nettype none

module naf_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read side
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ****************************************************************
  // Sequences
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken at one edge
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Read of an unmapped place
  sequence rd_bad;
    rd_take ##0 (s_axi_araddr >= 8'h18);
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_write_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write reply missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write reply dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while stalled");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read reply late");
  a_bad_read: assert property (rd_bad |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read reply not closed");
  a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write reply not closed");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during reply");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during reply");
endmodule // naf_chk

bind naf_top naf_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

`default_nettype wire

// *** bench/naf_adc_model.sv ***
// Purpose: Converter model emitting a steady sample stream.
// Assumes: Sample spacing scaled down to GAP clocks.
// Notes:   Alternates two values; line toggles between samples.
`timescale 1ns/1ps
`default_nettype none

module naf_adc_model #(
  parameter int GAP = 4
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Values to alternate
  input  wire logic [23:0] val_a,
  input  wire logic [23:0] val_b,
  // Sample stream
  output var  logic [23:0] adc_sample,
  output var  logic        adc_sample_valid
);
  int   cnt;   // Clocks since last sample
  logic pick;  // Which value goes next

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      pick <= 1'b0;
      adc_sample_valid <= 1'b0;
      adc_sample <= 24'h0;
    end else if (cnt == GAP - 1) begin
      cnt <= 0;
      pick <= !pick;
      adc_sample_valid <= 1'b1;
      adc_sample <= pick ? val_b : val_a;
    end else begin
      cnt <= cnt + 1;
      adc_sample_valid <= 1'b0;
      // Stale value never lingers between samples
      adc_sample <= ~adc_sample;
    end
  end
endmodule // naf_adc_model

`default_nettype wire

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the averaging notch filter.
// Assumes: Samples every GAP clocks, short built-in settle.
// Notes:   Bus replies are compared against a queue of notes.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int GAP = 4;  // Sample spacing in clocks
  localparam int DEF = 2;  // Built-in settle in us
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [23:0] val_a = 0, val_b = 0;
  logic [33:0] exp_q[$], msk_q[$], m;
  wire         awready, wready, bvalid, arready, rvalid, adc_valid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [23:0] adc_sample;
  int fail_count = 0, tests_run = 0, cyc = 0, seed = 32'he3c6, n, a, b, t, lo;
  int nt[4] = '{50, 60, 37500, 9375};
  int st[4] = '{1, 1, 0, 3};

  naf_adc_model #(.GAP(GAP)) u_adc (.aclk(aclk), .aresetn(aresetn), .val_a(val_a),
    .val_b(val_b), .adc_sample(adc_sample), .adc_sample_valid(adc_valid));
  naf_top #(.DEF_SETTLE_US(16'h0002)) dut (
    .aclk(aclk), .aresetn(aresetn), .adc_sample(adc_sample), .adc_sample_valid(adc_valid),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // Clock and cycle count
  always #4 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic conclude;
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One write; expected response noted first
  task automatic wr(input logic [7:0] ad, input int dv, input logic [1:0] rs);
    logic aw, w, bv;
    exp_q.push_back({rs, 32'h0});
    msk_q.push_back({2'b11, 32'h0});
    @(posedge aclk);
    awaddr <= ad; wdata <= 32'(dv); awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge aclk);
      aw = awready; w = wready; bv = bvalid;
      @(posedge aclk);
      if (aw) awvalid <= 0;
      if (w) wvalid <= 0;
    end while (!bv);
    bready <= 0;
  endtask

  // One read; expected reply and mask noted first
  task automatic rd(input logic [7:0] ad, input logic [33:0] e, input logic [33:0] mk,
                    output logic [31:0] dv);
    logic g, v;
    exp_q.push_back(e);
    msk_q.push_back(mk);
    @(posedge aclk);
    araddr <= ad; arvalid <= 1; rready <= 1;
    do begin
      @(negedge aclk);
      g = arready; v = rvalid; dv = rdata;
      @(posedge aclk);
      if (g) arvalid <= 0;
    end while (!v);
    rready <= 0;
  endtask

  // Start, then poll until idle; returns elapsed clocks
  task automatic run_meas(input int ctrl, output int el);
    logic [31:0] s;
    wr(8'h00, ctrl, 2'b00);
    el = cyc;
    do rd(8'h0C, 34'h0, 34'h0, s); while (s[0] !== 1'b0);
    el = cyc - el;
  endtask

  // Reply watcher: oldest note against each completed reply
  always @(negedge aclk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      m = msk_q.pop_front();
      check("bus reply", {rvalid ? rresp : bresp, rdata} & m, exp_q.pop_front() & m);
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rd(8'h04, 34'h32, '1, d);
    rd(8'h08, 34'h0, '1, d);
    rd(8'h18, {2'b10, 32'h0}, '1, d);
    wr(8'h14, 5, 2'b10);
    wr(8'h04, 0, 2'b00);
    run_meas(1, t);
    rd(8'h0C, 34'h8, 34'h8, d);
    wr(8'h0C, 8, 2'b00);
    rd(8'h0C, 34'h0, 34'h8, d);
    for (int i = 0; i < 4; i++) begin
      n = (187500 + nt[i]) / (2 * nt[i]);
      a = $random(seed) % 8388608;
      b = (i == 3) ? $random(seed) % 8388608 : a;
      val_a <= a[23:0];
      val_b <= b[23:0];
      wr(8'h04, nt[i], 2'b00);
      wr(8'h08, st[i], 2'b00);
      run_meas(1, t);
      lo = 125 * (st[i] != 0 ? st[i] : DEF) + (n - 1) * GAP + 250;
      check("result time", 34'(t >= lo && t <= lo + 200), 34'h1);
      rd(8'h14, 34'(n), '1, d);
      rd(8'h10, {2'b00, 32'((a + b) / 2)}, '1, d);
    end
    for (int r = 1; r <= 2; r++) begin
      run_meas(3, t);
      lo = 4 * (375 + 250 + 9 * GAP);
      check("bridge time", 34'(t >= lo && t <= lo + 500), 34'h1);
      rd(8'h0C, 34'(r * 64 + (r == 2) * 4), 34'hF4, d);
    end
    repeat (8) rd(8'h10, {2'b00, 32'((a + b) / 2)}, '1, d);
    rd(8'h10, 34'h0, '1, d);
    rd(8'h0C, 34'h0, 34'hF4, d);
    conclude();
  end

  // Watchdog
  initial begin
    #720000;
    fail_count++;
    conclude();
  end
endmodule // tb

`default_nettype wire
